//--- rtl/sfcwp_regs.svh
// field positions, opcodes, reset values and timing counts
// assumes: included by bare name from the sfcwp design files
`ifndef SFCWP_REGS_SVH
`define SFCWP_REGS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SFC_OP_WRITE_LATCH_SET 8'h06
`define SFC_OP_WRITE_LATCH_CLR 8'h04
`define SFC_OP_STATUS_READ     8'h05
`define SFC_OP_CONFIG_READ     8'h15
`define SFC_OP_REGISTER_WRITE  8'h01

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define SFC_SR_LOCK_BIT   7
`define SFC_SR_QUAD_BIT   6
`define SFC_SR_BP_HI      5
`define SFC_SR_BP_LO      2
`define SFC_SR_WEL_BIT    1
`define SFC_SR_BUSY_BIT   0
`define SFC_SR_RESET      8'h00

// ----------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------
`define SFC_CR_DUMMY_BIT  6
`define SFC_CR_BOTTOM_BIT 3
`define SFC_CR_DRIVE_BIT  0
`define SFC_CR_USED_MASK  8'h49
`define SFC_CR_RESET      8'h00

// ----------------------------------------------------------------
// dummy cycle counts
// ----------------------------------------------------------------
`define SFC_DUAL_DUMMY_LO 4'h4
`define SFC_DUAL_DUMMY_HI 4'h8
`define SFC_QUAD_DUMMY_LO 4'h6
`define SFC_QUAD_DUMMY_HI 4'ha

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SFC_CLK_PERIOD_NS       10
`define SFC_STATUS_WRITE_TIME_NS 5000000
`define SFC_STATUS_WRITE_CYCLES \
  ((`SFC_STATUS_WRITE_TIME_NS + `SFC_CLK_PERIOD_NS - 1) / `SFC_CLK_PERIOD_NS)

`endif

//--- rtl/sfcwp_pkg.sv
// types shared by the sfcwp design files
// assumes: nothing beyond a SystemVerilog compiler
package sfcwp_pkg;

  // ----------------------------------------------------------------
  // frame decoder states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    sfcwp_opcode,
    sfcwp_write_data,
    sfcwp_read_out,
    sfcwp_skip
  } sfcwp_state_type;

endpackage

//--- rtl/sfcwp_spi_rx.sv
// serial pin front end: synchronisers, edge detection, byte assembly
// assumes: sclk at most mclk/8, mode 0 (sample on rise, shift on fall)
`timescale 1ns/1ps
module sfcwp_spi_rx (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       si,
  input  wire logic       write_protect_n_io2,
  output logic            active_ff,
  output logic            cs_rise_ff,
  output logic            sclk_fall_ff,
  output logic            byte_stb_ff,
  output logic [7:0]      byte_ff,
  output logic [2:0]      byte_cnt_ff,
  output logic [2:0]      bit_cnt_ff,
  output logic            wp_n_ff
);

  // ----------------------------------------------------------------
  // synchronisers; only the second stage onward is looked at
  // ----------------------------------------------------------------
  logic [3:0] meta_ff, sync_ff, nxt_meta, nxt_sync;
  logic       sclk_old_ff, cs_old_ff, nxt_sclk_old, nxt_cs_old;
  logic       nxt_active, nxt_cs_rise, nxt_sclk_fall, nxt_byte_stb;
  logic [7:0] nxt_byte;
  logic [6:0] shift_ff, nxt_shift;
  logic [2:0] nxt_byte_cnt, nxt_bit_cnt;

  always_comb begin
    nxt_meta      = {write_protect_n_io2, si, cs_n, sclk};
    nxt_sync      = meta_ff;
    nxt_sclk_old  = sync_ff[0];
    nxt_cs_old    = sync_ff[1];
    nxt_active    = ~sync_ff[1];
    nxt_cs_rise   = sync_ff[1] & ~cs_old_ff;
    nxt_sclk_fall = ~sync_ff[0] & sclk_old_ff & ~sync_ff[1];
    nxt_byte_stb  = 1'b0;
    nxt_byte      = byte_ff;
    nxt_shift     = shift_ff;
    nxt_byte_cnt  = byte_cnt_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    if (sync_ff[1]) begin
      // hold both counts one cycle so the frame end sees where select rose
      if (~cs_old_ff) begin
        nxt_byte_cnt = byte_cnt_ff;
        nxt_bit_cnt  = bit_cnt_ff;
      end else begin
        nxt_byte_cnt = 3'h0;
        nxt_bit_cnt  = 3'h0;
      end
    end else if (sync_ff[0] & ~sclk_old_ff) begin
      nxt_bit_cnt = bit_cnt_ff + 3'h1;
      nxt_shift   = {shift_ff[5:0], sync_ff[2]};
      if (bit_cnt_ff == 3'h7) begin
        nxt_byte_stb = 1'b1;
        nxt_byte     = {shift_ff, sync_ff[2]};
        // saturate so an overlong frame stays visible
        if (byte_cnt_ff != 3'h7) begin
          nxt_byte_cnt = byte_cnt_ff + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_ff      <= 4'ha;
      sync_ff      <= 4'ha;
      sclk_old_ff  <= 1'b0;
      cs_old_ff    <= 1'b1;
      active_ff    <= 1'b0;
      cs_rise_ff   <= 1'b0;
      sclk_fall_ff <= 1'b0;
      byte_stb_ff  <= 1'b0;
      byte_ff      <= 8'h00;
      shift_ff     <= 7'h00;
      byte_cnt_ff  <= 3'h0;
      bit_cnt_ff   <= 3'h0;
    end else begin
      meta_ff      <= nxt_meta;
      sync_ff      <= nxt_sync;
      sclk_old_ff  <= nxt_sclk_old;
      cs_old_ff    <= nxt_cs_old;
      active_ff    <= nxt_active;
      cs_rise_ff   <= nxt_cs_rise;
      sclk_fall_ff <= nxt_sclk_fall;
      byte_stb_ff  <= nxt_byte_stb;
      byte_ff      <= nxt_byte;
      shift_ff     <= nxt_shift;
      byte_cnt_ff  <= nxt_byte_cnt;
      bit_cnt_ff   <= nxt_bit_cnt;
    end
  end

  assign wp_n_ff = sync_ff[3];

endmodule

//--- rtl/sfcwp_top.sv
// status and configuration register write path with write protection
// assumes: serial pins asynchronous to mclk, sclk no faster than mclk/8
`timescale 1ns/1ps
`include "sfcwp_regs.svh"
module sfcwp_top #(
  parameter int unsigned STATUS_WRITE_CYCLES = `SFC_STATUS_WRITE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       si,
  input  wire logic       write_protect_n_io2,
  output logic            so_ff,
  output logic            so_oe_ff,
  output logic            busy_flag_ff,
  output logic            write_enable_latch_ff,
  output logic            hardware_protection_ff,
  output logic            software_protection_ff,
  output logic            quad_enable_ff,
  output logic [3:0]      block_protect_ff,
  output logic            protect_from_bottom_ff,
  output logic            output_drive_strength_ff,
  output logic            dummy_count_select_ff,
  output logic [3:0]      dual_io_dummy_ff,
  output logic [3:0]      quad_io_dummy_ff
);

  // ----------------------------------------------------------------
  // pin front end
  // ----------------------------------------------------------------
  logic       active, cs_rise, sclk_fall, byte_stb, wp_n;
  logic [7:0] rx_byte;
  logic [2:0] byte_cnt, bit_cnt;

  sfcwp_spi_rx u_rx (
    .mclk                (mclk),
    .reset_n             (reset_n),
    .sclk                (sclk),
    .cs_n                (cs_n),
    .si                  (si),
    .write_protect_n_io2 (write_protect_n_io2),
    .active_ff           (active),
    .cs_rise_ff          (cs_rise),
    .sclk_fall_ff        (sclk_fall),
    .byte_stb_ff         (byte_stb),
    .byte_ff             (rx_byte),
    .byte_cnt_ff         (byte_cnt),
    .bit_cnt_ff          (bit_cnt),
    .wp_n_ff             (wp_n)
  );

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  function automatic logic [7:0] status_image(input logic lock, input logic quad,
                                              input logic [3:0] bp, input logic write_enable_latch,
                                              input logic busy);
    status_image = {lock, quad, bp, write_enable_latch, busy};
  endfunction

  function automatic logic [7:0] config_image(input logic dummy, input logic bottom,
                                              input logic drive);
    config_image = {1'b0, dummy, 2'b00, bottom, 2'b00, drive};
  endfunction

  sfcwp_pkg::sfcwp_state_type state_ff, nxt_state;
  logic [7:0]  opcode_ff, nxt_opcode;
  logic [7:0]  stage_sr_ff, nxt_stage_sr, stage_cr_ff, nxt_stage_cr;
  logic        stage_has_cr_ff, nxt_stage_has_cr;
  logic [31:0] timer_ff, nxt_timer;
  logic [7:0]  tx_ff, nxt_tx;
  logic [2:0]  tx_bits_ff, nxt_tx_bits;
  logic        nxt_so, nxt_so_oe, nxt_busy, nxt_wel, nxt_hpm, nxt_spm, nxt_quad;
  logic [3:0]  nxt_bp;
  logic        nxt_bottom, nxt_drive, nxt_dummy, lock_ff, nxt_lock;
  logic [3:0]  nxt_dual_dummy, nxt_quad_dummy;
  logic        on_boundary, write_ok;
  logic [7:0]  read_byte;

  always_comb begin
    nxt_state        = state_ff;
    nxt_opcode       = opcode_ff;
    nxt_stage_sr     = stage_sr_ff;
    nxt_stage_cr     = stage_cr_ff;
    nxt_stage_has_cr = stage_has_cr_ff;
    nxt_timer        = timer_ff;
    nxt_tx           = tx_ff;
    nxt_tx_bits      = tx_bits_ff;
    nxt_so           = so_ff;
    nxt_busy         = busy_flag_ff;
    nxt_wel          = write_enable_latch_ff;
    nxt_quad         = quad_enable_ff;
    nxt_bp           = block_protect_ff;
    nxt_lock         = lock_ff;
    nxt_bottom       = protect_from_bottom_ff;
    nxt_drive        = output_drive_strength_ff;
    nxt_dummy        = dummy_count_select_ff;
    on_boundary      = (bit_cnt == 3'h0);
    // busy blocks a second write from starting a cycle; its bytes still overwrite the staged image
    write_ok = write_enable_latch_ff & ~hardware_protection_ff & ~busy_flag_ff;
    if (opcode_ff == `SFC_OP_CONFIG_READ) begin
      read_byte = config_image(dummy_count_select_ff, protect_from_bottom_ff,
                               output_drive_strength_ff);
    end else begin
      read_byte = status_image(lock_ff, quad_enable_ff, block_protect_ff,
                               write_enable_latch_ff, busy_flag_ff);
    end

    // frame decoding
    if (byte_stb) begin
      case (state_ff)
        sfcwp_pkg::sfcwp_opcode: begin
          nxt_opcode = rx_byte;
          case (rx_byte)
            `SFC_OP_REGISTER_WRITE: begin
              nxt_state = sfcwp_pkg::sfcwp_write_data;
            end
            `SFC_OP_STATUS_READ, `SFC_OP_CONFIG_READ: begin
              nxt_state   = sfcwp_pkg::sfcwp_read_out;
              nxt_tx_bits = 3'h0;
            end
            default: begin
              nxt_state = sfcwp_pkg::sfcwp_skip;
            end
          endcase
        end
        sfcwp_pkg::sfcwp_write_data: begin
          if (byte_cnt == 3'h2) begin
            nxt_stage_sr     = rx_byte;
            nxt_stage_has_cr = 1'b0;
          end else if (byte_cnt == 3'h3) begin
            nxt_stage_cr     = rx_byte & `SFC_CR_USED_MASK;
            nxt_stage_has_cr = 1'b1;
          end
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end

    // status or config shifts out msb first on each falling edge, repeating while selected
    if (state_ff == sfcwp_pkg::sfcwp_read_out && sclk_fall) begin
      if (tx_bits_ff == 3'h0) begin
        nxt_so = read_byte[7];
        nxt_tx = {read_byte[6:0], 1'b0};
      end else begin
        nxt_so = tx_ff[7];
        nxt_tx = {tx_ff[6:0], 1'b0};
      end
      nxt_tx_bits = tx_bits_ff + 3'h1;
    end
    nxt_so_oe = active & (state_ff == sfcwp_pkg::sfcwp_read_out);

    // frame end: commands act only on a whole-byte boundary
    if (cs_rise) begin
      nxt_state = sfcwp_pkg::sfcwp_opcode;
      nxt_so    = 1'b0;
      if (on_boundary && byte_cnt == 3'h1 && !busy_flag_ff) begin
        if (opcode_ff == `SFC_OP_WRITE_LATCH_SET) begin
          nxt_wel = 1'b1;
        end else if (opcode_ff == `SFC_OP_WRITE_LATCH_CLR) begin
          nxt_wel = 1'b0;
        end
      end
      if (state_ff == sfcwp_pkg::sfcwp_write_data && on_boundary && write_ok &&
          (byte_cnt == 3'h2 || byte_cnt == 3'h3)) begin
        nxt_busy  = 1'b1;
        nxt_timer = STATUS_WRITE_CYCLES;
      end
    end

    // self-timed write cycle; commit only at the end
    if (busy_flag_ff) begin
      if (timer_ff <= 32'h1) begin
        nxt_busy   = 1'b0;
        nxt_wel    = 1'b0;
        nxt_timer  = 32'h0;
        nxt_lock   = stage_sr_ff[`SFC_SR_LOCK_BIT];
        nxt_quad   = stage_sr_ff[`SFC_SR_QUAD_BIT];
        nxt_bp     = stage_sr_ff[`SFC_SR_BP_HI:`SFC_SR_BP_LO];
        if (stage_has_cr_ff) begin
          nxt_drive  = stage_cr_ff[`SFC_CR_DRIVE_BIT];
          nxt_dummy  = stage_cr_ff[`SFC_CR_DUMMY_BIT];
          // one-time programmable: can only go from 0 to 1
          nxt_bottom = protect_from_bottom_ff | stage_cr_ff[`SFC_CR_BOTTOM_BIT];
        end
      end else begin
        nxt_timer = timer_ff - 32'h1;
      end
    end

    // protection mode from the committed lock and quad bits and the pin
    nxt_hpm        = nxt_lock & ~wp_n & ~nxt_quad;
    nxt_spm        = ~nxt_hpm;
    nxt_dual_dummy = nxt_dummy ? `SFC_DUAL_DUMMY_HI : `SFC_DUAL_DUMMY_LO;
    nxt_quad_dummy = nxt_dummy ? `SFC_QUAD_DUMMY_HI : `SFC_QUAD_DUMMY_LO;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_ff                 <= sfcwp_pkg::sfcwp_opcode;
      opcode_ff                <= 8'h00;
      stage_sr_ff              <= `SFC_SR_RESET;
      stage_cr_ff              <= `SFC_CR_RESET;
      stage_has_cr_ff          <= 1'b0;
      timer_ff                 <= 32'h0;
      tx_ff                    <= 8'h00;
      tx_bits_ff               <= 3'h0;
      so_ff                    <= 1'b0;
      so_oe_ff                 <= 1'b0;
      busy_flag_ff             <= 1'b0;
      write_enable_latch_ff    <= 1'b0;
      hardware_protection_ff   <= 1'b0;
      software_protection_ff   <= 1'b1;
      quad_enable_ff           <= 1'b0;
      block_protect_ff         <= 4'h0;
      lock_ff                  <= 1'b0;
      protect_from_bottom_ff   <= 1'b0;
      output_drive_strength_ff <= 1'b0;
      dummy_count_select_ff    <= 1'b0;
      dual_io_dummy_ff         <= `SFC_DUAL_DUMMY_LO;
      quad_io_dummy_ff         <= `SFC_QUAD_DUMMY_LO;
    end else begin
      state_ff                 <= nxt_state;
      opcode_ff                <= nxt_opcode;
      stage_sr_ff              <= nxt_stage_sr;
      stage_cr_ff              <= nxt_stage_cr;
      stage_has_cr_ff          <= nxt_stage_has_cr;
      timer_ff                 <= nxt_timer;
      tx_ff                    <= nxt_tx;
      tx_bits_ff               <= nxt_tx_bits;
      so_ff                    <= nxt_so;
      so_oe_ff                 <= nxt_so_oe;
      busy_flag_ff             <= nxt_busy;
      write_enable_latch_ff    <= nxt_wel;
      hardware_protection_ff   <= nxt_hpm;
      software_protection_ff   <= nxt_spm;
      quad_enable_ff           <= nxt_quad;
      block_protect_ff         <= nxt_bp;
      lock_ff                  <= nxt_lock;
      protect_from_bottom_ff   <= nxt_bottom;
      output_drive_strength_ff <= nxt_drive;
      dummy_count_select_ff    <= nxt_dummy;
      dual_io_dummy_ff         <= nxt_dual_dummy;
      quad_io_dummy_ff         <= nxt_quad_dummy;
    end
  end

endmodule

//--- verif/sfcwp_props.sv
// checker on the sfcwp_top ports: busy timing, commit points, protect modes
// assumes: bound to sfcwp_top from the bench top file
`timescale 1ns/1ps
`include "sfcwp_regs.svh"
module sfcwp_props #(
  parameter int unsigned STATUS_WRITE_CYCLES = 20
) (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       cs_n,
  input wire logic       so_oe_ff,
  input wire logic       write_protect_n_io2,
  input wire logic       busy_flag_ff,
  input wire logic       write_enable_latch_ff,
  input wire logic       hardware_protection_ff,
  input wire logic       software_protection_ff,
  input wire logic       quad_enable_ff,
  input wire logic [3:0] block_protect_ff,
  input wire logic       protect_from_bottom_ff,
  input wire logic       output_drive_strength_ff,
  input wire logic       dummy_count_select_ff,
  input wire logic [3:0] dual_io_dummy_ff,
  input wire logic [3:0] quad_io_dummy_ff
);
  // ----------------------------------------------------------------
  // busy length counter
  // ----------------------------------------------------------------
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;
  always_comb begin
    nxt_busy_cnt = busy_flag_ff ? busy_cnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      busy_cnt_ff <= 32'h0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_commit;
    $fell(busy_flag_ff);
  endsequence
  // pin passes two sync flops, so five samples give margin
  sequence s_pin_high;
    write_protect_n_io2 [*5];
  endsequence
  sequence s_cs_idle;
    cs_n [*5];
  endsequence
  AST_OE_IDLE: assert property (s_cs_idle |-> !so_oe_ff)
    else $error("output enable high while deselected");
  AST_BUSY_LEN: assert property (s_commit |-> busy_cnt_ff == STATUS_WRITE_CYCLES)
    else $error("busy length wrong");
  AST_LATCH_CLR: assert property (s_commit |-> !write_enable_latch_ff)
    else $error("latch not cleared at end of write");
  AST_BUSY_START: assert property ($rose(busy_flag_ff) |-> cs_n && $past(cs_n, 3))
    else $error("busy rose without select high");
  AST_DRIVE_COMMIT: assert property ($changed(output_drive_strength_ff) |-> s_commit)
    else $error("drive strength changed outside commit");
  AST_BP_COMMIT: assert property ($changed(block_protect_ff) |-> s_commit)
    else $error("protect bits changed outside commit");
  AST_BOTTOM_OTP: assert property ($past(protect_from_bottom_ff) |-> protect_from_bottom_ff)
    else $error("bottom bit cleared");
  AST_MODE_EXCL: assert property (software_protection_ff != hardware_protection_ff)
    else $error("protect modes not exclusive");
  AST_PIN_HIGH: assert property (s_pin_high |=> !hardware_protection_ff)
    else $error("hardware mode with pin high");
  AST_QUAD_NO_HPM: assert property (quad_enable_ff && $past(quad_enable_ff)
                                    |-> !hardware_protection_ff)
    else $error("hardware mode with quad enabled");
  AST_DUAL_DUMMY: assert property (dual_io_dummy_ff == (dummy_count_select_ff ?
                                   `SFC_DUAL_DUMMY_HI : `SFC_DUAL_DUMMY_LO))
    else $error("dual dummy count wrong");
  AST_QUAD_DUMMY: assert property (quad_io_dummy_ff == (dummy_count_select_ff ?
                                   `SFC_QUAD_DUMMY_HI : `SFC_QUAD_DUMMY_LO))
    else $error("quad dummy count wrong");
endmodule

//--- verif/sfcwp_host.sv
// host serial controller model: frames commands on cs_n, sclk, si
// assumes: mode 0, msb first, sclk half period of 6 mclk, 7 for the high half of read bits
`timescale 1ns/1ps
module sfcwp_host (
  input  wire logic mclk,
  input  wire logic so_ff,
  output logic      sclk,
  output logic      cs_n,
  output logic      si
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b1;
  end
  task automatic half();
    repeat (6) @(posedge mclk);
  endtask
  // nbits from bit 23 down; a count off a byte edge breaks the frame
  task automatic frame(input logic [23:0] data, input int nbits, input int nrd,
                       output logic [7:0] rd);
    rd = 8'h00;
    @(posedge mclk);
    cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si <= data[23 - i];
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
    for (int j = 0; j < nrd; j++) begin
      si <= ~si;
      half();
      sclk <= 1'b1;
      half();
      @(negedge mclk) rd[7 - j] = so_ff;
      @(posedge mclk) sclk <= 1'b0;
    end
    half();
    cs_n <= 1'b1;
    si   <= ~si;
    // end on a falling edge so callers read settled outputs
    repeat (8) @(negedge mclk);
  endtask
endmodule

//--- verif/tb.sv
// bench top: drives sfcwp_top through the host model and judges the ports
// assumes: write time shortened by parameter, protect pin driven here
`timescale 1ns/1ps
module tb;
  localparam int unsigned WCYC = 400;
  logic       mclk;
  logic       reset_n;
  logic       sclk;
  logic       cs_n;
  logic       si;
  logic       write_protect_n_io2;
  logic       so_ff;
  logic       busy_flag_ff;
  logic       write_enable_latch_ff;
  logic       hardware_protection_ff;
  logic       software_protection_ff;
  logic       quad_enable_ff;
  logic [3:0] block_protect_ff;
  logic       protect_from_bottom_ff;
  logic       output_drive_strength_ff;
  logic       dummy_count_select_ff;
  logic [3:0] dual_io_dummy_ff;
  logic [3:0] quad_io_dummy_ff;
  logic       saw_busy;
  logic       saw_oe;
  logic       so_oe_ff;
  logic [7:0] rd;
  int         num_errors;
  int         compares;
  sfcwp_top #(.STATUS_WRITE_CYCLES(WCYC)) u_sfcwp_top (
    .mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .si(si),
    .write_protect_n_io2(write_protect_n_io2), .so_ff(so_ff), .so_oe_ff(so_oe_ff),
    .busy_flag_ff(busy_flag_ff), .write_enable_latch_ff(write_enable_latch_ff),
    .hardware_protection_ff(hardware_protection_ff),
    .software_protection_ff(software_protection_ff), .quad_enable_ff(quad_enable_ff),
    .block_protect_ff(block_protect_ff), .protect_from_bottom_ff(protect_from_bottom_ff),
    .output_drive_strength_ff(output_drive_strength_ff),
    .dummy_count_select_ff(dummy_count_select_ff), .dual_io_dummy_ff(dual_io_dummy_ff),
    .quad_io_dummy_ff(quad_io_dummy_ff));
  sfcwp_host u_sfcwp_host (.mclk(mclk), .so_ff(so_ff), .sclk(sclk), .cs_n(cs_n), .si(si));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (busy_flag_ff === 1'b1) saw_busy <= 1'b1;
    if (so_oe_ff === 1'b1) saw_oe <= 1'b1;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk1(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] sr, input logic [7:0] cr, input int nbits);
    saw_busy = 1'b0;
    u_sfcwp_host.frame({8'h06, 16'h0000}, 8, 0, rd);
    u_sfcwp_host.frame({8'h01, sr, cr}, nbits, 0, rd);
  endtask
  // fixed span covers the whole shortened write cycle
  task automatic done(input logic exp);
    repeat (WCYC + 100) @(negedge mclk);
    chk1("busy seen", exp, saw_busy);
    chk1("busy idle", 1'b0, busy_flag_ff);
  endtask
  task automatic set_pin(input logic lvl);
    @(posedge mclk) write_protect_n_io2 <= lvl;
    repeat (8) @(negedge mclk);
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk1("busy", 1'b0, busy_flag_ff);
    chk1("latch", 1'b0, write_enable_latch_ff);
    chk1("sw mode", 1'b1, software_protection_ff);
    chk8("dual", 8'h04, 8'(dual_io_dummy_ff));
    chk8("quad dummy", 8'h06, 8'(quad_io_dummy_ff));
  endtask
  task automatic t_no_latch();
    saw_busy = 1'b0;
    u_sfcwp_host.frame({8'h01, 8'h3c, 8'h00}, 24, 0, rd);
    done(1'b0);
    chk8("bp", 8'h00, 8'(block_protect_ff));
    chk1("oe seen", 1'b0, saw_oe);
  endtask
  task automatic t_write();
    wr(8'hbf, 8'hff, 24);
    chk1("latch", 1'b1, write_enable_latch_ff);
    u_sfcwp_host.frame({8'h05, 16'h0000}, 8, 8, rd);
    chk8("status busy", 8'h03, rd);
    chk1("oe seen", 1'b1, saw_oe);
    chk1("oe idle", 1'b0, so_oe_ff);
    chk8("bp early", 8'h00, 8'(block_protect_ff));
    done(1'b1);
    chk1("latch", 1'b0, write_enable_latch_ff);
    chk8("bp", 8'h0f, 8'(block_protect_ff));
    chk1("quad", 1'b0, quad_enable_ff);
    chk1("bottom", 1'b1, protect_from_bottom_ff);
    chk1("drive", 1'b1, output_drive_strength_ff);
    chk8("dual", 8'h08, 8'(dual_io_dummy_ff));
    chk8("quad dummy", 8'h0a, 8'(quad_io_dummy_ff));
    u_sfcwp_host.frame({8'h15, 16'h0000}, 8, 8, rd);
    chk8("config", 8'h49, rd);
    u_sfcwp_host.frame({8'h05, 16'h0000}, 8, 8, rd);
    chk8("status", 8'hbc, rd);
  endtask
  task automatic t_otp();
    wr(8'hbc, 8'h00, 24);
    done(1'b1);
    chk1("bottom", 1'b1, protect_from_bottom_ff);
    chk1("drive", 1'b0, output_drive_strength_ff);
    chk1("dummy", 1'b0, dummy_count_select_ff);
  endtask
  task automatic t_boundary();
    wr(8'h00, 8'h00, 20);
    done(1'b0);
    chk8("bp", 8'h0f, 8'(block_protect_ff));
    chk1("latch kept", 1'b1, write_enable_latch_ff);
    u_sfcwp_host.frame({8'h04, 16'h0000}, 8, 0, rd);
    chk1("latch cleared", 1'b0, write_enable_latch_ff);
  endtask
  task automatic t_hpm();
    set_pin(1'b0);
    chk1("hw mode", 1'b1, hardware_protection_ff);
    chk1("sw mode", 1'b0, software_protection_ff);
    wr(8'h00, 8'h00, 24);
    done(1'b0);
    chk8("bp", 8'h0f, 8'(block_protect_ff));
    set_pin(1'b1);
    chk1("hw mode", 1'b0, hardware_protection_ff);
  endtask
  task automatic t_spm();
    wr(8'h00, 8'hff, 16);
    done(1'b1);
    chk8("bp", 8'h00, 8'(block_protect_ff));
    chk1("bottom", 1'b1, protect_from_bottom_ff);
    set_pin(1'b0);
    chk1("hw mode", 1'b0, hardware_protection_ff);
    wr(8'hc4, 8'h00, 16);
    done(1'b1);
    chk1("quad", 1'b1, quad_enable_ff);
    chk8("bp", 8'h01, 8'(block_protect_ff));
    repeat (8) @(negedge mclk);
    chk1("hw mode", 1'b0, hardware_protection_ff);
  endtask
  initial begin
    num_errors = 0;
    compares = 0;
    saw_busy = 1'b0;
    saw_oe = 1'b0;
    reset_n = 1'b0;
    write_protect_n_io2 = 1'b1;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (8) @(negedge mclk);
    t_reset();
    t_no_latch();
    t_write();
    t_otp();
    t_boundary();
    t_hpm();
    t_spm();
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    wrap_up();
  end
endmodule
bind sfcwp_top sfcwp_props #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_sfcwp_props (
  .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .write_protect_n_io2(write_protect_n_io2),
  .so_oe_ff(so_oe_ff),
  .busy_flag_ff(busy_flag_ff), .write_enable_latch_ff(write_enable_latch_ff),
  .hardware_protection_ff(hardware_protection_ff),
  .software_protection_ff(software_protection_ff), .quad_enable_ff(quad_enable_ff),
  .block_protect_ff(block_protect_ff), .protect_from_bottom_ff(protect_from_bottom_ff),
  .output_drive_strength_ff(output_drive_strength_ff),
  .dummy_count_select_ff(dummy_count_select_ff), .dual_io_dummy_ff(dual_io_dummy_ff),
  .quad_io_dummy_ff(quad_io_dummy_ff));
